// *** logic/amc_pkg.sv ***
// shared constants and types for the amplifier control block
`default_nettype none
package amc_pkg;
   // mode control bit positions
   localparam int MODE_SRC_A_BIT  = 2;
   localparam int MODE_SRC_B_BIT  = 3;
   localparam int MODE_POWER_BIT  = 4;
   // diagnostic control bit positions
   localparam int DIAG_ILIM_BIT   = 1;
   localparam int DIAG_CLEAR_BIT  = 2;
   localparam int DIAG_CONT_BIT   = 3;
   localparam int DIAG_RUN_BIT    = 4;
   // fault mask bit positions
   localparam int MASK_OUT_SHORT  = 0;
   localparam int MASK_OPEN       = 1;
   localparam int MASK_RAIL       = 2;
   localparam int MASK_OVERCUR    = 3;
   localparam int MASK_THERMAL    = 4;
   // reset values
   localparam logic [4:0] MODE_RESET = 5'h00;
   localparam logic [4:0] DIAG_RESET_VAL = 5'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;
   // diagnostic step lengths
   localparam int    CLK_MHZ          = 100;
   localparam int    DIAG_STEP_US     = 10;
   localparam int    DIAG_STEP_CYC    = DIAG_STEP_US * CLK_MHZ;
   localparam logic [10:0] DIAG_STEP_LAST = 11'(DIAG_STEP_CYC - 1);
   localparam int    DIAG_PERIOD_MS   = 60;
   localparam int    DIAG_PERIOD_CYC  = DIAG_PERIOD_MS * 1000 * CLK_MHZ;
   // sequence states
   typedef enum logic [1:0] {
      AMC_IDLE  = 2'b00,
      AMC_RAIL  = 2'b01,
      AMC_LOAD  = 2'b10,
      AMC_WAIT  = 2'b11
   } amc_diag_st_t;
   // routing selections
   typedef enum logic [1:0] {
      AMC_MUTE  = 2'b00,
      AMC_SRC_A = 2'b01,
      AMC_SRC_B = 2'b10,
      AMC_MIX   = 2'b11
   } amc_route_t;
endpackage : amc_pkg
`default_nettype wire

// *** logic/amc_sync.sv ***
// two-flop synchroniser for one level
`default_nettype none
module amc_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic meta_r;
      logic q_r;
   } amc_sync_st_t;
   amc_sync_st_t st_r;
   amc_sync_st_t st_nxt;
   // shift the level through two flops
   always_comb begin
      st_nxt.meta_r = d;
      st_nxt.q_r    = st_r.meta_r;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.q_r;
endmodule : amc_sync
`default_nettype wire

// *** logic/amc_gain_lut.sv ***
// volume code to gain lookup, gain in tenths of a dB
`default_nettype none
module amc_gain_lut (
   input  wire logic [4:0]  code,
   output logic      [10:0] gain_tenth_db
);
   // lookup of the 32 gain steps, signed tenths of a dB
   always_comb begin
      unique case (code)
         5'h00: gain_tenth_db = -11'sd800;
         5'h01: gain_tenth_db = -11'sd540;
         5'h02: gain_tenth_db = -11'sd405;
         5'h03: gain_tenth_db = -11'sd345;
         5'h04: gain_tenth_db = -11'sd300;
         5'h05: gain_tenth_db = -11'sd270;
         5'h06: gain_tenth_db = -11'sd240;
         5'h07: gain_tenth_db = -11'sd210;
         5'h08: gain_tenth_db = -11'sd180;
         5'h09: gain_tenth_db = -11'sd150;
         5'h0a: gain_tenth_db = -11'sd135;
         5'h0b: gain_tenth_db = -11'sd120;
         5'h0c: gain_tenth_db = -11'sd105;
         5'h0d: gain_tenth_db = -11'sd90;
         5'h0e: gain_tenth_db = -11'sd75;
         5'h0f: gain_tenth_db = -11'sd60;
         5'h10: gain_tenth_db = -11'sd45;
         5'h11: gain_tenth_db = -11'sd30;
         5'h12: gain_tenth_db = -11'sd15;
         5'h13: gain_tenth_db = 11'sd0;
         5'h14: gain_tenth_db = 11'sd15;
         5'h15: gain_tenth_db = 11'sd30;
         5'h16: gain_tenth_db = 11'sd45;
         5'h17: gain_tenth_db = 11'sd60;
         5'h18: gain_tenth_db = 11'sd75;
         5'h19: gain_tenth_db = 11'sd90;
         5'h1a: gain_tenth_db = 11'sd105;
         5'h1b: gain_tenth_db = 11'sd120;
         5'h1c: gain_tenth_db = 11'sd135;
         5'h1d: gain_tenth_db = 11'sd150;
         5'h1e: gain_tenth_db = 11'sd165;
         5'h1f: gain_tenth_db = 11'sd180;
      endcase
   end
endmodule : amc_gain_lut
`default_nettype wire

// *** logic/amc_ctrl.sv ***
// amplifier mode, fault latch and volume control top
// What this block does
// - mode bits 2 and 3 select source a and source b separately
// - none mutes, a only, b only, both gives mono mix
// - rail short flag disables outputs and pulls fault low
// - output short or open load disables outputs, pulls fault low
// - open load checked only in diagnostic sequence, never while idle
// - diagnostic bit 1 picks fixed or supply dependent current limit
// - over-current flag disables outputs and pulls fault low
// - over-current protection acts with diagnostics disabled
// - over-temperature flag disables outputs and pulls fault low
// - thermal protection acts with diagnostics disabled
// - fault pin asserts only for tests not masked
// - fault stays low until the clear bit is toggled
// - fault pin is open drain: only pulls low or releases
// - each source has a 5-bit code looked up to 32 gain steps
// - power bit 0 shuts down with outputs off, 1 enables
// - rising edge of the diagnostic run bit starts the sequence
// - masked tests skip the fault pin but still shut down
// - toggling the clear bit re-enables outputs and releases fault
`default_nettype none
module amc_ctrl (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        link_clk,
   input  wire logic [4:0]  mode_ctrl,
   input  wire logic [4:0]  diag_ctrl,
   input  wire logic [4:0]  fault_mask,
   input  wire logic [4:0]  gain_code_a,
   input  wire logic [4:0]  gain_code_b,
   input  wire logic        det_rail_short,
   input  wire logic        det_out_short,
   input  wire logic        det_open_load,
   input  wire logic        det_overcur,
   input  wire logic        det_overtemp,
   output logic             fault_n_o,
   output logic             fault_n_oe,
   output logic             outputs_en,
   output logic             current_limit_mode,
   output logic             open_test_en,
   output logic             rail_test_en,
   output logic [1:0]       route_sel,
   output logic [10:0]      gain_a,
   output logic [10:0]      gain_b,
   output logic             diag_busy,
   output logic [4:0]       fault_seen
);
   // control fields as the core uses them, taken from the word filter
   logic [4:0] mode_s;
   logic [4:0] diag_s;
   logic [4:0] mask_s;
   logic [4:0] gca_s;
   logic [4:0] gcb_s;
   logic [4:0] det_s;
   logic [10:0] gain_a_w;
   logic [10:0] gain_b_w;
   // raw synchroniser outputs; bits of one word may land a cycle apart
   logic [24:0] cfg_y;

   // link-side capture of host fields, held in the link domain
   typedef struct packed {
      logic [4:0] mode;
      logic [4:0] diag;
      logic [4:0] mask;
      logic [4:0] gca;
      logic [4:0] gcb;
   } amc_link_st_t;
   amc_link_st_t lk_r;
   amc_link_st_t lk_nxt;
   always_comb begin
      lk_nxt = '{mode_ctrl, diag_ctrl, fault_mask, gain_code_a, gain_code_b};
   end
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         lk_r <= '{mode: amc_pkg::MODE_RESET, diag: amc_pkg::DIAG_RESET_VAL,
                   mask: amc_pkg::MASK_RESET, default: '0};
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // cross every bit into the core clock; bits are static between writes
   for (genvar i = 0; i < 5; i++) begin : g_sync
      amc_sync u_mode (.clk(clk), .rstn(rstn), .d(lk_r.mode[i]), .q(cfg_y[20 + i]));
      amc_sync u_diag (.clk(clk), .rstn(rstn), .d(lk_r.diag[i]), .q(cfg_y[15 + i]));
      amc_sync u_mask (.clk(clk), .rstn(rstn), .d(lk_r.mask[i]), .q(cfg_y[10 + i]));
      amc_sync u_gca  (.clk(clk), .rstn(rstn), .d(lk_r.gca[i]),  .q(cfg_y[5 + i]));
      amc_sync u_gcb  (.clk(clk), .rstn(rstn), .d(lk_r.gcb[i]),  .q(cfg_y[i]));
   end

   // synchronise the five analog detector flags
   amc_sync u_det0 (.clk(clk), .rstn(rstn), .d(det_out_short),  .q(det_s[0]));
   amc_sync u_det1 (.clk(clk), .rstn(rstn), .d(det_open_load),  .q(det_s[1]));
   amc_sync u_det2 (.clk(clk), .rstn(rstn), .d(det_rail_short), .q(det_s[2]));
   amc_sync u_det3 (.clk(clk), .rstn(rstn), .d(det_overcur),    .q(det_s[3]));
   amc_sync u_det4 (.clk(clk), .rstn(rstn), .d(det_overtemp),   .q(det_s[4]));

   amc_gain_lut u_lut_a (.code(gca_s), .gain_tenth_db(gain_a_w));
   amc_gain_lut u_lut_b (.code(gcb_s), .gain_tenth_db(gain_b_w));

   typedef struct packed {
      amc_pkg::amc_diag_st_t diag_st;
      logic [10:0]           step_cnt;
      logic                  init_pending;
      logic                  run_prev;
      logic                  clear_prev;
      logic                  shutdown;
      logic                  fault_pin;
      logic [4:0]            seen;
      logic                  out_en;
      logic                  ilim;
      logic                  open_en;
      logic                  rail_en;
      logic [1:0]            route;
      logic [10:0]           ga;
      logic [10:0]           gb;
      logic [24:0]           cfg_raw;
      logic [24:0]           cfg;
      logic                  busy;
   } amc_core_st_t;
   amc_core_st_t st_r;
   amc_core_st_t st_nxt;

   // filtered word splits back into its fields
   assign {mode_s, diag_s, mask_s, gca_s, gcb_s} = st_r.cfg;

   logic       run_rise;
   logic       clear_tog;
   logic [4:0] live;
   logic [4:0] shut_hit;

   // main sequencing, protection and fault latch
   always_comb begin
      st_nxt    = st_r;
      // take a crossed word only when it reads the same on two edges,
      // so bits that land a cycle apart never show a mixed word
      st_nxt.cfg_raw = cfg_y;
      if (cfg_y == st_r.cfg_raw) begin
         st_nxt.cfg = cfg_y;
      end
      // run bit rising edge starts a sequence
      run_rise  = diag_s[amc_pkg::DIAG_RUN_BIT] & ~st_r.run_prev;
      // clear acts on either edge of the toggle bit
      clear_tog = diag_s[amc_pkg::DIAG_CLEAR_BIT] ^ st_r.clear_prev;
      st_nxt.run_prev   = diag_s[amc_pkg::DIAG_RUN_BIT];
      st_nxt.clear_prev = diag_s[amc_pkg::DIAG_CLEAR_BIT];
      // current limit mode follows diagnostic bit 1
      st_nxt.ilim = diag_s[amc_pkg::DIAG_ILIM_BIT];
      // short and open tests only live inside the sequence
      live = det_s & {1'b1, 1'b1, st_r.rail_en, st_r.open_en, st_r.open_en};
      // over-current and thermal flags always live
      live[amc_pkg::MASK_OVERCUR] = det_s[amc_pkg::MASK_OVERCUR];
      live[amc_pkg::MASK_THERMAL] = det_s[amc_pkg::MASK_THERMAL];
      // any live fault shuts the outputs down
      shut_hit = live;
      if (|shut_hit) begin
         st_nxt.shutdown = 1'b1;
      end
      if (|(live & ~mask_s)) begin
         st_nxt.fault_pin = 1'b1;
      end
      st_nxt.seen = st_r.seen | live;
      // only the toggle clears, a new fault wins
      if (clear_tog) begin
         st_nxt.shutdown  = |shut_hit;
         st_nxt.fault_pin = |(live & ~mask_s);
         st_nxt.seen      = live;
      end
      // diagnostic sequence: rail step then load step
      st_nxt.step_cnt = st_r.step_cnt + 11'h001;
      unique case (st_r.diag_st)
         amc_pkg::AMC_IDLE: begin
            st_nxt.step_cnt = '0;
            if (st_r.init_pending || run_rise) begin
               st_nxt.diag_st      = amc_pkg::AMC_RAIL;
               st_nxt.rail_en      = 1'b1;
            end
         end
         amc_pkg::AMC_RAIL: begin
            if (st_r.step_cnt == amc_pkg::DIAG_STEP_LAST) begin
               st_nxt.diag_st  = amc_pkg::AMC_LOAD;
               st_nxt.step_cnt = '0;
               st_nxt.rail_en  = 1'b0;
               st_nxt.open_en  = 1'b1;
            end
         end
         amc_pkg::AMC_LOAD: begin
            if (st_r.step_cnt == amc_pkg::DIAG_STEP_LAST) begin
               st_nxt.diag_st  = amc_pkg::AMC_WAIT;
               st_nxt.step_cnt = '0;
               st_nxt.open_en  = 1'b0;
            end
         end
         amc_pkg::AMC_WAIT: begin
            st_nxt.diag_st      = amc_pkg::AMC_IDLE;
            st_nxt.step_cnt     = '0;
            // power-up run stays pending, outputs off, until it ends
            st_nxt.init_pending = 1'b0;
         end
      endcase
      // clearing aborts a sequence in progress, the power-up run too
      if (clear_tog && st_r.diag_st != amc_pkg::AMC_IDLE) begin
         st_nxt.diag_st      = amc_pkg::AMC_IDLE;
         st_nxt.rail_en      = 1'b0;
         st_nxt.open_en      = 1'b0;
         st_nxt.step_cnt     = '0;
         st_nxt.init_pending = 1'b0;
      end
      // power bit gates the outputs; the power-up run keeps them off
      st_nxt.out_en = mode_s[amc_pkg::MODE_POWER_BIT] & ~st_nxt.shutdown
                      & ~st_nxt.init_pending;
      // busy flag registered so the output comes from a flop
      st_nxt.busy = (st_nxt.diag_st != amc_pkg::AMC_IDLE);
      // routing from the two select bits
      st_nxt.route = {mode_s[amc_pkg::MODE_SRC_B_BIT], mode_s[amc_pkg::MODE_SRC_A_BIT]};
      st_nxt.ga = gain_a_w;
      st_nxt.gb = gain_b_w;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r              <= '0;
         st_r.init_pending <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops, except fault_n_o tied low
   assign fault_n_o          = 1'b0;
   // only enable a low drive, never drive high
   assign fault_n_oe         = st_r.fault_pin;
   assign outputs_en         = st_r.out_en;
   assign current_limit_mode = st_r.ilim;
   assign open_test_en       = st_r.open_en;
   assign rail_test_en       = st_r.rail_en;
   assign route_sel          = st_r.route;
   assign gain_a             = st_r.ga;
   assign gain_b             = st_r.gb;
   assign diag_busy          = st_r.busy;
   assign fault_seen         = st_r.seen;

   // unmasked live fault pulls the pin within one cycle
   fault_assert_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (|(live & ~mask_s)) |=> fault_n_oe)
      else $error("unmasked fault did not pull the pin");
   // pin holds without a clear toggle
   fault_hold_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (fault_n_oe && !clear_tog) |=> fault_n_oe)
      else $error("fault pin released without clear");
   // any live fault turns outputs off
   prot_off_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (|live) |=> !outputs_en)
      else $error("outputs left on during fault");
   // power bit low keeps outputs off
   power_off_a:
   assert property (@(posedge clk) disable iff (!rstn)
      !mode_s[amc_pkg::MODE_POWER_BIT] |=> !outputs_en)
      else $error("outputs on in shutdown");
   // open test never runs idle
   open_idle_a:
   assert property (@(posedge clk) disable iff (!rstn)
      open_test_en |-> st_r.diag_st == amc_pkg::AMC_LOAD)
      else $error("open test outside sequence");
   // rising run bit starts a sequence
   run_start_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (run_rise && !diag_busy && !clear_tog) |=> rail_test_en)
      else $error("run edge did not start sequence");
   // routing follows select bits one cycle later
   route_sel_a:
   assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> route_sel == $past({mode_s[3], mode_s[2]}))
      else $error("routing mismatch");
   // thermal shuts down even if masked
   therm_mask_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (det_s[amc_pkg::MASK_THERMAL] && mask_s[amc_pkg::MASK_THERMAL]) |=> !outputs_en)
      else $error("masked thermal did not shut down");
   // a clear with no live unmasked fault releases the pin
   clear_rel_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (clear_tog && !(|(live & ~mask_s))) |=> !fault_n_oe)
      else $error("clear did not release the pin");
   // current limit mode follows its control bit
   ilim_follow_a:
   assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> current_limit_mode == $past(diag_s[amc_pkg::DIAG_ILIM_BIT]))
      else $error("current limit mode mismatch");
   // rail short during the rail step turns outputs off
   rail_shut_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (det_s[amc_pkg::MASK_RAIL] && rail_test_en) |=> !outputs_en)
      else $error("rail short left outputs on");
   // power-up run keeps outputs off
   init_off_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (diag_busy && st_r.init_pending) |-> !outputs_en)
      else $error("outputs on during power-up run");
endmodule : amc_ctrl
`default_nettype wire

// *** tb/amc_host_model.sv ***
// control bus host model that drives the configuration fields over the link clock
`default_nettype none
module amc_host_model (
   output logic       link_clk,
   output logic [4:0] mode_ctrl,
   output logic [4:0] diag_ctrl,
   output logic [4:0] fault_mask,
   output logic [4:0] gain_code_a,
   output logic [4:0] gain_code_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle: link clock parked low, fields at their reset values
   initial begin
      link_clk    = 1'b0;
      mode_ctrl   = 5'h00;
      diag_ctrl   = 5'h00;
      fault_mask  = 5'h00;
      gain_code_a = 5'h00;
      gain_code_b = 5'h00;
   end

   // one write: update a field, then clock the link only for this frame
   task automatic wr(input int sel, input logic [4:0] val);
      #3;
      case (sel)
         0: mode_ctrl = val;
         1: diag_ctrl = val;
         2: fault_mask = val;
         3: gain_code_a = val;
         default: gain_code_b = val;
      endcase
      repeat (12) #16 link_clk = ~link_clk; // six 32 ns periods, ends low
   endtask : wr
endmodule : amc_host_model
`default_nettype wire

// *** tb/amc_ctrl_bench.sv ***
// self-checking bench for the amplifier control block
`default_nettype none
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module amc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, link_clk;
   logic [4:0]  mode_ctrl, diag_ctrl, fault_mask, gain_code_a, gain_code_b, dets, diag_sh;
   logic        fault_n_o, fault_n_oe, outputs_en, current_limit_mode;
   logic        open_test_en, rail_test_en, diag_busy;
   logic [1:0]  route_sel;
   logic [10:0] gain_a, gain_b;
   logic [4:0]  fault_seen;
   int          miscompares, num_checks;
   // gain per volume code in tenths of a dB
   localparam int GAIN_TAB[32] = '{-800, -540, -405, -345, -300, -270, -240, -210,
      -180, -150, -135, -120, -105, -90, -75, -60, -45, -30, -15, 0,
      15, 30, 45, 60, 75, 90, 105, 120, 135, 150, 165, 180};

   amc_ctrl u_amc_ctrl (.clk(clk), .rstn(rstn), .link_clk(link_clk), .mode_ctrl(mode_ctrl),
      .diag_ctrl(diag_ctrl), .fault_mask(fault_mask), .gain_code_a(gain_code_a),
      .gain_code_b(gain_code_b), .det_rail_short(dets[2]), .det_out_short(dets[0]),
      .det_open_load(dets[1]), .det_overcur(dets[3]), .det_overtemp(dets[4]),
      .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .outputs_en(outputs_en),
      .current_limit_mode(current_limit_mode), .open_test_en(open_test_en),
      .rail_test_en(rail_test_en), .route_sel(route_sel), .gain_a(gain_a),
      .gain_b(gain_b), .diag_busy(diag_busy), .fault_seen(fault_seen));
   amc_host_model u_amc_host_model (.link_clk(link_clk), .mode_ctrl(mode_ctrl),
      .diag_ctrl(diag_ctrl), .fault_mask(fault_mask), .gain_code_a(gain_code_a),
      .gain_code_b(gain_code_b));

   function automatic logic [10:0] exp_gain(input logic [4:0] c);
      return 11'(GAIN_TAB[c]);
   endfunction : exp_gain

   task automatic finish_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // host write, then let the core sync flops settle
   task automatic wr(input int sel, input logic [4:0] v);
      u_amc_host_model.wr(sel, v);
      repeat (6) @(negedge clk);
   endtask : wr

   // flip the clear bit; either edge releases the latch
   task automatic clear_tog();
      diag_sh[amc_pkg::DIAG_CLEAR_BIT] = ~diag_sh[amc_pkg::DIAG_CLEAR_BIT];
      wr(1, diag_sh);
   endtask : clear_tog

   // bounded wait for the fault pin to be pulled
   task automatic wait_fault();
      int n;
      n = 0;
      while (fault_n_oe !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_fault

   // core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog against a hang
   initial begin
      #400000;
      miscompares++;
      finish_test();
   end

   // main sequence
   initial begin
      logic [4:0] c;
      rstn = 1'b0;
      dets = 5'h00;
      diag_sh = amc_pkg::DIAG_RESET_VAL;
      void'($urandom(32'h5c63));
      repeat (10) @(negedge clk);
      `chk(fault_n_o, 1'b0)
      `chk(fault_n_oe, 1'b0)
      rstn = 1'b1;
      repeat (20) @(negedge clk);
      `chk(diag_busy, 1'b1)
      // power-up run holds outputs off even with power on
      wr(0, 5'h10);
      `chk(outputs_en, 1'b0)
      `chk(rail_test_en, 1'b1)
      wr(0, 5'h00);
      repeat (2100) @(negedge clk);
      `chk(outputs_en, 1'b0)
      for (int i = 0; i < 4; i++) begin
         wr(0, 5'(16 + i * 4));
         `chk(route_sel, 2'(i))
         `chk(outputs_en, 1'b1)
      end
      wr(0, 5'h08);
      `chk(route_sel, 2'b10)
      `chk(outputs_en, 1'b0)
      wr(0, 5'h1c);
      // gain lookup corners and random codes
      for (int i = 0; i < 8; i++) begin
         c = (i == 0) ? 5'h00 : (i == 1) ? 5'h13 : (i == 2) ? 5'h1f : 5'($urandom);
         wr(3, c);
         wr(4, ~c);
         `chk(gain_a, exp_gain(c))
         `chk(gain_b, exp_gain(~c))
      end
      for (int i = 0; i < 2; i++) begin
         diag_sh[amc_pkg::DIAG_ILIM_BIT] = 1'(i);
         wr(1, diag_sh);
         `chk(current_limit_mode, 1'(i))
      end
      // live protection, masked and unmasked, diagnostics off
      for (int k = 3; k < 5; k++) begin
         for (int m = 0; m < 2; m++) begin
            wr(2, (m == 1) ? 5'(1 << k) : amc_pkg::MASK_RESET);
            dets[k] = 1'b1;
            repeat (4) @(negedge clk);
            `chk(outputs_en, 1'b0)
            `chk(fault_n_oe, 1'(m == 0))
            if (m == 0) `chk(fault_seen[k], 1'b1)
            dets[k] = 1'b0;
            repeat (8) @(negedge clk);
            `chk(fault_n_oe, 1'(m == 0))
            clear_tog();
            `chk(fault_n_oe, 1'b0)
            `chk(outputs_en, 1'b1)
         end
      end
      wr(2, amc_pkg::MASK_RESET);
      // load and rail flags ignored while idle
      dets = 5'h07;
      repeat (10) @(negedge clk);
      `chk(fault_n_oe, 1'b0)
      `chk(outputs_en, 1'b1)
      `chk(open_test_en, 1'b0)
      `chk(rail_test_en, 1'b0)
      dets = 5'h00;
      // faults caught by a triggered sequence
      for (int k = 0; k < 3; k++) begin
         dets[k] = 1'b1;
         diag_sh[amc_pkg::DIAG_RUN_BIT] = 1'b0;
         wr(1, diag_sh);
         diag_sh[amc_pkg::DIAG_RUN_BIT] = 1'b1;
         wr(1, diag_sh);
         `chk(diag_busy, 1'b1)
         `chk(rail_test_en, 1'b1)
         wait_fault();
         `chk(open_test_en, 1'(k < 2))
         `chk(fault_n_oe, 1'b1)
         `chk(outputs_en, 1'b0)
         `chk(fault_seen[k], 1'b1)
         dets[k] = 1'b0;
         clear_tog();
         `chk(fault_n_oe, 1'b0)
      end
      finish_test();
   end
endmodule : amc_ctrl_bench
`default_nettype wire
